// ### hw/scm_defs.svh
// Constants of the sensor correction datapath: register map, field
// positions, reset values and saturation limits.
// Assumes byte addresses on an 8-bit register port with 32-bit data.
`ifndef SCM_DEFS_SVH
`define SCM_DEFS_SVH

// Register byte addresses
`define SCM_ADDR_COEF_LAST 8'h28
`define SCM_ADDR_CTRL      8'h30
`define SCM_ADDR_STAT      8'h34
`define SCM_ADDR_CLR       8'h38
`define SCM_ADDR_IEN       8'h3C
`define SCM_ADDR_BRIDGE    8'h40
`define SCM_ADDR_TEMP      8'h44
`define SCM_ADDR_MSTAT     8'h48

// Field positions
`define SCM_CTRL_CURVE     0
`define SCM_EV_SAT         0
`define SCM_EV_DONE        1
`define SCM_MSTAT_SAT      0
`define SCM_MSTAT_BUSY     1

// Reset values
`define SCM_RST_COEF       18'sh00000
`define SCM_RST_EV         2'h0

// Coefficient indices
`define SCM_CI_GAIN_B      4'h0
`define SCM_CI_OFFS_B      4'h1
`define SCM_CI_TCG         4'h2
`define SCM_CI_TCO         4'h3
`define SCM_CI_TSETL       4'h4
`define SCM_CI_GAIN_DRIFT_SECOND_ORDER_COEF     4'h5
`define SCM_CI_OFFSET_DRIFT_SECOND_ORDER_COEF     4'h6
`define SCM_CI_BRIDGE_SECOND_ORDER_COEF  4'h7
`define SCM_CI_GAIN_T      4'h8
`define SCM_CI_OFFS_T      4'h9
`define SCM_CI_TEMP_SECOND_ORDER_COEF       4'hA

// Coefficient and raw input bounds
`define SCM_C_P1FFFF       32'sh0001FFFF
`define SCM_C_M1FFFF       32'shFFFE0001
`define SCM_C_PFFFF        32'sh0000FFFF
`define SCM_C_MFFFF        32'shFFFF0001
`define SCM_C_P1FFF        32'sh00001FFF
`define SCM_C_M1FFF        32'shFFFFE001
`define SCM_RAW_MIN        18'sh20001

// Arithmetic limits and constants, 19-bit and 18-bit signed
`define SCM_LIM_S18_HI     19'sh1FFFF
`define SCM_LIM_S18_LO     19'sh60000
`define SCM_LIM_ZERO       19'sh00000
`define SCM_LIM_U16        19'sh0FFFF
`define SCM_LIM_2P16       19'sh10000
`define SCM_S18_MAX        18'sh1FFFF
`define SCM_S18_MIN        18'sh20000
`define SCM_HALF           18'sh08000
`define SCM_NULL           18'sh00000
`define SCM_FRAC           15

`endif

// ### hw/scm_pkg.sv
// Types of the sensor correction datapath.
// Assumes scm_defs.svh is on the include path.
package scm_pkg;

	typedef struct packed {
		logic signed [17:0] rawBridge;
		logic signed [17:0] rawTemp;
	} scm_raw_t;

	typedef struct packed {
		logic [15:0] bridge;
		logic [16:0] temp;
		logic        sat;
	} scm_result_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h00,
		ST_DT   = 5'h01,
		ST_K1A  = 5'h03,
		ST_K1B  = 5'h02,
		ST_K1C  = 5'h06,
		ST_K1D  = 5'h07,
		ST_K2A  = 5'h05,
		ST_K2B  = 5'h04,
		ST_K2C  = 5'h0C,
		ST_K2D  = 5'h0D,
		ST_K2E  = 5'h0F,
		ST_Z1   = 5'h0E,
		ST_Z2   = 5'h0A,
		ST_Z3   = 5'h0B,
		ST_B1   = 5'h09,
		ST_B2   = 5'h08,
		ST_B3   = 5'h18,
		ST_B4   = 5'h19,
		ST_T1   = 5'h1B,
		ST_T2   = 5'h1A,
		ST_T3   = 5'h1E,
		ST_T4   = 5'h1F,
		ST_T5   = 5'h1D,
		ST_T6   = 5'h1C
	} scm_state_t;

endpackage

// ### hw/scm_sat_unit.sv
// Saturating arithmetic step: scaled product or sum, clamped to bounds.
// Assumes operands are 18-bit signed and bounds lie within 19 bits.
`timescale 1ns/1ps
`include "scm_defs.svh"

module scm_sat_unit (
	// Operation
	input  wire logic               mulSel,
	input  wire logic signed [17:0] opA,
	input  wire logic signed [17:0] opB,
	// Bounds
	input  wire logic signed [18:0] limLo,
	input  wire logic signed [18:0] limHi,
	// Result
	output logic signed      [17:0] res,
	output logic                    sat
);

	logic signed [35:0] prod;
	logic signed [36:0] full;
	logic signed [36:0] lo;
	logic signed [36:0] hi;

	always_comb begin
		prod = opA * opB;
		// Divide by 2^15 as arithmetic shift, truncating
		if (mulSel) begin
			full = 37'(prod >>> `SCM_FRAC);
		end else begin
			full = 37'(opA) + 37'(opB);
		end
		lo = 37'(limLo);
		hi = 37'(limHi);
		if (full > hi) begin
			res = 18'(hi);
			sat = 1'b1;
		end else if (full < lo) begin
			res = 18'(lo);
			sat = 1'b1;
		end else begin
			res = 18'(full);
			sat = 1'b0;
		end
	end

endmodule

// ### hw/scm_core.sv
// Sensor correction datapath with coefficient registers and interrupt.
// Assumes start and raw readings come from logic on clk; host reaches
// registers over a plain address/strobe port, read data one cycle late.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "scm_defs.svh"

module scm_core #(
	parameter int COEF_NUM = 11
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// Measurement request
	input  wire logic                 start,
	input  wire scm_pkg::scm_raw_t    rawIn,
	// Measurement answer
	output scm_pkg::scm_result_t      result,
	output logic                      done,
	output logic                      busy,
	// Register port
	input  wire logic [7:0]           regAddr,
	input  wire logic [31:0]          regWdata,
	input  wire logic                 regWr,
	input  wire logic                 regRd,
	output logic [31:0]               regRdata,
	// Interrupt
	output logic                      irq
);

	////////////////////////////////////////////////////////////////////
	// Coefficient store

	logic signed [17:0] coef [COEF_NUM];
	logic               curveSel_r;

	function automatic logic signed [17:0] clampCoef(
		input logic [3:0]         idx,
		input logic signed [31:0] v
	);
		logic signed [31:0] lo;
		logic signed [31:0] hi;
		lo = `SCM_C_M1FFFF;
		hi = `SCM_C_P1FFFF;
		case (idx)
			`SCM_CI_TSETL: begin
				lo = `SCM_C_MFFFF;
				hi = `SCM_C_PFFFF;
			end
			`SCM_CI_GAIN_DRIFT_SECOND_ORDER_COEF, `SCM_CI_OFFSET_DRIFT_SECOND_ORDER_COEF: begin
				lo = `SCM_C_M1FFF;
			end
			`SCM_CI_OFFS_T, `SCM_CI_TEMP_SECOND_ORDER_COEF: begin
				lo = `SCM_C_M1FFF;
				hi = `SCM_C_P1FFF;
			end
			default: begin
				lo = `SCM_C_M1FFFF;
			end
		endcase
		if (v > hi) begin
			clampCoef = 18'(hi);
		end else if (v < lo) begin
			clampCoef = 18'(lo);
		end else begin
			clampCoef = 18'(v);
		end
	endfunction

	generate
		for (genvar gi = 0; gi < COEF_NUM; gi++) begin : gCoef
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					coef[gi] <= `SCM_RST_COEF;
				end else if (regWr && regAddr == 8'(gi * 4)) begin
					coef[gi] <= clampCoef(4'(gi), regWdata);
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			curveSel_r <= 1'b0;
		end else if (regWr && regAddr == `SCM_ADDR_CTRL) begin
			curveSel_r <= regWdata[`SCM_CTRL_CURVE];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sequencer and working registers

	scm_pkg::scm_state_t state_r;
	scm_pkg::scm_state_t state_nxt;
	logic signed [17:0]  rawB_r;
	logic signed [17:0]  rawT_r;
	logic                curve_r;
	logic signed [17:0]  dT_r;
	logic signed [17:0]  k1_r;
	logic signed [17:0]  k2_r;
	logic signed [17:0]  p_r;
	logic signed [17:0]  z_r;
	logic                measSat_r;

	logic               mulSel;
	logic signed [17:0] opA;
	logic signed [17:0] opB;
	logic signed [18:0] limLo;
	logic signed [18:0] limHi;
	logic signed [17:0] stepRes;
	logic               stepSat;
	logic signed [17:0] absZ;
	logic               absSat;

	function automatic logic signed [17:0] clampRaw(
		input logic signed [17:0] v
	);
		clampRaw = (v < `SCM_RAW_MIN) ? `SCM_RAW_MIN : v;
	endfunction

	always_comb begin
		absSat = (z_r == `SCM_S18_MIN);
		if (absSat) begin
			absZ = `SCM_S18_MAX;
		end else if (z_r < 0) begin
			absZ = -z_r;
		end else begin
			absZ = z_r;
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			scm_pkg::ST_IDLE: state_nxt = start ? scm_pkg::ST_DT : state_r;
			scm_pkg::ST_DT:  state_nxt = scm_pkg::ST_K1A;
			scm_pkg::ST_K1A: state_nxt = scm_pkg::ST_K1B;
			scm_pkg::ST_K1B: state_nxt = scm_pkg::ST_K1C;
			scm_pkg::ST_K1C: state_nxt = scm_pkg::ST_K1D;
			scm_pkg::ST_K1D: state_nxt = scm_pkg::ST_K2A;
			scm_pkg::ST_K2A: state_nxt = scm_pkg::ST_K2B;
			scm_pkg::ST_K2B: state_nxt = scm_pkg::ST_K2C;
			scm_pkg::ST_K2C: state_nxt = scm_pkg::ST_K2D;
			scm_pkg::ST_K2D: state_nxt = scm_pkg::ST_K2E;
			scm_pkg::ST_K2E: state_nxt = scm_pkg::ST_Z1;
			scm_pkg::ST_Z1:  state_nxt = scm_pkg::ST_Z2;
			scm_pkg::ST_Z2:  state_nxt = scm_pkg::ST_Z3;
			scm_pkg::ST_Z3:  state_nxt = scm_pkg::ST_B1;
			scm_pkg::ST_B1:  state_nxt = scm_pkg::ST_B2;
			scm_pkg::ST_B2:  state_nxt = scm_pkg::ST_B3;
			scm_pkg::ST_B3:  state_nxt = scm_pkg::ST_B4;
			scm_pkg::ST_B4:  state_nxt = scm_pkg::ST_T1;
			scm_pkg::ST_T1:  state_nxt = scm_pkg::ST_T2;
			scm_pkg::ST_T2:  state_nxt = scm_pkg::ST_T3;
			scm_pkg::ST_T3:  state_nxt = scm_pkg::ST_T4;
			scm_pkg::ST_T4:  state_nxt = scm_pkg::ST_T5;
			scm_pkg::ST_T5:  state_nxt = scm_pkg::ST_T6;
			scm_pkg::ST_T6:  state_nxt = scm_pkg::ST_IDLE;
			default:         state_nxt = scm_pkg::ST_IDLE;
		endcase
	end

	// Operand and bound selection for the single arithmetic step
	always_comb begin
		mulSel = 1'b0;
		opA    = `SCM_NULL;
		opB    = `SCM_NULL;
		limLo  = `SCM_LIM_S18_LO;
		limHi  = `SCM_LIM_S18_HI;
		case (state_r)
			scm_pkg::ST_DT: begin
				opA = rawT_r;
				opB = -coef[`SCM_CI_TSETL];
			end
			scm_pkg::ST_K1A: begin
				mulSel = 1'b1;
				opA    = coef[`SCM_CI_GAIN_DRIFT_SECOND_ORDER_COEF];
				opB    = dT_r;
			end
			scm_pkg::ST_K1B: begin
				opA = p_r;
				opB = coef[`SCM_CI_TCG];
			end
			scm_pkg::ST_K1C, scm_pkg::ST_K2C: begin
				mulSel = 1'b1;
				opA    = dT_r;
				opB    = p_r;
			end
			scm_pkg::ST_K1D: begin
				opA = `SCM_HALF;
				opB = p_r;
			end
			scm_pkg::ST_K2A: begin
				mulSel = 1'b1;
				opA    = coef[`SCM_CI_OFFSET_DRIFT_SECOND_ORDER_COEF];
				opB    = dT_r;
			end
			scm_pkg::ST_K2B: begin
				opA = p_r;
				opB = coef[`SCM_CI_TCO];
			end
			scm_pkg::ST_K2D: begin
				opA = rawB_r;
				opB = p_r;
			end
			scm_pkg::ST_K2E: begin
				opA = coef[`SCM_CI_OFFS_B];
				opB = p_r;
			end
			scm_pkg::ST_Z1: begin
				mulSel = 1'b1;
				opA    = k1_r;
				opB    = k2_r;
			end
			scm_pkg::ST_Z2: begin
				mulSel = 1'b1;
				opA    = coef[`SCM_CI_GAIN_B];
				opB    = p_r;
			end
			scm_pkg::ST_Z3: begin
				opA = z_r;
				if (!curve_r) begin
					opB   = `SCM_HALF;
					limLo = `SCM_LIM_ZERO;
				end
			end
			scm_pkg::ST_B1: begin
				mulSel = 1'b1;
				opA    = coef[`SCM_CI_BRIDGE_SECOND_ORDER_COEF];
				opB    = curve_r ? absZ : z_r;
			end
			scm_pkg::ST_B2: begin
				opA = p_r;
				opB = `SCM_HALF;
			end
			scm_pkg::ST_B3: begin
				mulSel = 1'b1;
				opA    = z_r;
				opB    = p_r;
				if (!curve_r) begin
					limLo = `SCM_LIM_ZERO;
					limHi = `SCM_LIM_U16;
				end
			end
			scm_pkg::ST_B4: begin
				opA   = p_r;
				opB   = curve_r ? `SCM_HALF : `SCM_NULL;
				limLo = `SCM_LIM_ZERO;
				limHi = curve_r ? `SCM_LIM_2P16 : `SCM_LIM_U16;
			end
			scm_pkg::ST_T1: begin
				opA = rawT_r;
				opB = coef[`SCM_CI_OFFS_T];
			end
			scm_pkg::ST_T2: begin
				mulSel = 1'b1;
				opA    = coef[`SCM_CI_GAIN_T];
				opB    = p_r;
			end
			scm_pkg::ST_T3: begin
				opA   = p_r;
				opB   = `SCM_HALF;
				limLo = `SCM_LIM_ZERO;
			end
			scm_pkg::ST_T4: begin
				mulSel = 1'b1;
				opA    = coef[`SCM_CI_TEMP_SECOND_ORDER_COEF];
				opB    = z_r;
			end
			scm_pkg::ST_T5: begin
				opA = p_r;
				opB = `SCM_HALF;
			end
			scm_pkg::ST_T6: begin
				mulSel = 1'b1;
				opA    = z_r;
				opB    = p_r;
				limLo  = `SCM_LIM_ZERO;
			end
			default: begin
				mulSel = 1'b0;
			end
		endcase
	end

	scm_sat_unit uStep (
		.mulSel (mulSel),
		.opA    (opA),
		.opB    (opB),
		.limLo  (limLo),
		.limHi  (limHi),
		.res    (stepRes),
		.sat    (stepSat)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= scm_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Inputs latched on start; a start while busy is ignored
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rawB_r  <= `SCM_NULL;
			rawT_r  <= `SCM_NULL;
			curve_r <= 1'b0;
		end else if (start && state_r == scm_pkg::ST_IDLE) begin
			rawB_r  <= clampRaw(rawIn.rawBridge);
			rawT_r  <= clampRaw(rawIn.rawTemp);
			curve_r <= curveSel_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dT_r <= `SCM_NULL;
			k1_r <= `SCM_NULL;
			k2_r <= `SCM_NULL;
			p_r  <= `SCM_NULL;
			z_r  <= `SCM_NULL;
		end else begin
			case (state_r)
				scm_pkg::ST_DT:  dT_r <= stepRes;
				scm_pkg::ST_K1D: k1_r <= stepRes;
				scm_pkg::ST_K2E: k2_r <= stepRes;
				scm_pkg::ST_Z2, scm_pkg::ST_Z3, scm_pkg::ST_T3: z_r <= stepRes;
				scm_pkg::ST_IDLE, scm_pkg::ST_B4, scm_pkg::ST_T6: p_r <= p_r;
				default:         p_r <= stepRes;
			endcase
		end
	end

	// Saturation of any step, including |shaped|, marks the measurement
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			measSat_r <= 1'b0;
		end else if (state_r == scm_pkg::ST_IDLE) begin
			measSat_r <= 1'b0;
		end else begin
			measSat_r <= measSat_r | stepSat |
				(state_r == scm_pkg::ST_B1 && curve_r && absSat);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Result outputs

	logic measDone;
	assign measDone = (state_r == scm_pkg::ST_T6);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			result <= '0;
			done   <= 1'b0;
			busy   <= 1'b0;
		end else begin
			done <= measDone;
			busy <= (state_nxt != scm_pkg::ST_IDLE);
			if (state_r == scm_pkg::ST_B4) begin
				// Full-scale 2^16 is delivered as FFFF
				result.bridge <= stepRes[16] ? '1 : stepRes[15:0];
			end
			if (measDone) begin
				result.temp <= stepRes[16:0];
				result.sat  <= measSat_r | stepSat;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt status, clear and enable

	logic [1:0] evStat_r;
	logic [1:0] evIen_r;
	logic [1:0] evSet;
	logic [1:0] evClr;

	assign evSet = {measDone, measDone & (measSat_r | stepSat)};
	assign evClr = (regWr && regAddr == `SCM_ADDR_CLR) ? regWdata[1:0] : 2'h0;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			evStat_r <= `SCM_RST_EV;
			evIen_r  <= `SCM_RST_EV;
			irq      <= 1'b0;
		end else begin
			evStat_r <= (evStat_r & ~evClr) | evSet;
			if (regWr && regAddr == `SCM_ADDR_IEN) begin
				evIen_r <= regWdata[1:0];
			end
			irq <= |(evStat_r & evIen_r);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register read

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regRdata <= '0;
		end else if (regRd) begin
			regRdata <= '0;
			if (regAddr <= `SCM_ADDR_COEF_LAST && regAddr[1:0] == 2'h0) begin
				regRdata <= 32'(coef[regAddr[5:2]]);
			end else begin
				case (regAddr)
					`SCM_ADDR_CTRL:   regRdata <= 32'(curveSel_r);
					`SCM_ADDR_STAT:   regRdata <= 32'(evStat_r);
					`SCM_ADDR_IEN:    regRdata <= 32'(evIen_r);
					`SCM_ADDR_BRIDGE: regRdata <= 32'(result.bridge);
					`SCM_ADDR_TEMP:   regRdata <= 32'(result.temp);
					`SCM_ADDR_MSTAT:  regRdata <= 32'({busy, result.sat});
					default:          regRdata <= '0;
				endcase
			end
		end else begin
			regRdata <= '0;
		end
	end

endmodule

// ### bench/scm_core_monitor.sv
// Checker of the correction datapath, watching the core's ports only.
// Assumes scm_defs.svh on the include path; bound to scm_core below.
`timescale 1ns/1ps
`include "scm_defs.svh"

module scm_core_monitor (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// Measurement
	input  wire logic                 start,
	input  wire scm_pkg::scm_raw_t    rawIn,
	input  wire scm_pkg::scm_result_t result,
	input  wire logic                 done,
	input  wire logic                 busy,
	// Register port
	input  wire logic [7:0]           regAddr,
	input  wire logic [31:0]          regWdata,
	input  wire logic                 regWr,
	input  wire logic                 regRd,
	input  wire logic [31:0]          regRdata,
	input  wire logic                 irq
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_done_latency:
	assert property (start && !busy |-> ##24 done)
		else $error("done not 24 cycles after accepted start");
	a_done_single:
	assert property (done |=> !done) else $error("done longer than one cycle");
	a_done_idle:
	assert property (done |-> !busy) else $error("busy high with done");
	a_result_hold:
	assert property (!busy && !start |=> $stable(result))
		else $error("result changed while idle");
	a_bridge_read:
	assert property (regRd && regAddr == `SCM_ADDR_BRIDGE |=>
		regRdata == {16'h0000, $past(result.bridge)})
		else $error("bridge register differs from result");
	a_temp_read:
	assert property (regRd && regAddr == `SCM_ADDR_TEMP |=>
		regRdata == {15'h0000, $past(result.temp)})
		else $error("temperature register differs from result");
	a_sat_read:
	assert property (regRd && regAddr == `SCM_ADDR_MSTAT |=>
		regRdata[0] == $past(result.sat))
		else $error("status bit 0 differs from saturation flag");
	a_gain_bound:
	assert property (regRd && regAddr == 8'h00 |=>
		$signed(regRdata) <= `SCM_C_P1FFFF && $signed(regRdata) >= `SCM_C_M1FFFF)
		else $error("bridge gain outside bounds");
	a_tpoint_bound:
	assert property (regRd && regAddr == 8'h10 |=>
		$signed(regRdata) <= `SCM_C_PFFFF && $signed(regRdata) >= `SCM_C_MFFFF)
		else $error("calibration point outside bounds");
	a_toff_bound:
	assert property (regRd && regAddr == 8'h24 |=>
		$signed(regRdata) <= `SCM_C_P1FFF && $signed(regRdata) >= `SCM_C_M1FFF)
		else $error("temperature offset outside bounds");
	a_clear_irq:
	assert property (regWr && regAddr == `SCM_ADDR_CLR &&
		regWdata[1:0] == 2'h3 ##1 !done |=> !irq)
		else $error("interrupt stays after full clear");
	a_busy_start:
	assert property (start && !busy |=> busy)
		else $error("busy not raised after accepted start");
endmodule

bind scm_core scm_core_monitor u_mon (.clk(clk), .rst_n(rst_n),
	.start(start), .rawIn(rawIn), .result(result), .done(done),
	.busy(busy), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
	.regRd(regRd), .regRdata(regRdata), .irq(irq));

// ### bench/scm_conv_model.sv
// Converter result path model: issues readings, waits for the answer.
// Assumes the core's one-cycle start and done handshake on clk.
`timescale 1ns/1ps

module scm_conv_model (
	// Clock
	input  wire logic        clk,
	// Request
	output scm_pkg::scm_raw_t rawIn,
	output logic             start,
	// Answer
	input  wire logic        done
);
	initial begin
		start = 1'b0;
		rawIn = '0;
	end

	task automatic measure(input logic signed [17:0] b,
		input logic signed [17:0] t, output logic ok);
		int n;
		ok = 1'b0;
		n = 0;
		@(posedge clk);
		start <= 1'b1;
		rawIn.rawBridge <= b;
		rawIn.rawTemp <= t;
		@(posedge clk);
		start <= 1'b0;
		// Released reading no longer holds its value
		rawIn <= ~rawIn;
		while (!ok && n < 40) begin
			@(posedge clk);
			#1;
			ok = done;
			n++;
		end
	endtask
endmodule

// ### bench/tb_top.sv
// Testbench of the correction datapath: registers, math, interrupt.
// Assumes scm_defs.svh on the include path and the core's contract.
`timescale 1ns/1ps
`include "scm_defs.svh"

module tb_top;
	logic                 clk;
	logic                 rst_n;
	logic                 start;
	logic                 done;
	logic                 busy;
	logic                 irq;
	logic                 regWr;
	logic                 regRd;
	logic                 ok;
	logic [7:0]           regAddr;
	logic [31:0]          regWdata;
	logic [31:0]          regRdata;
	logic [31:0]          rdVal;
	scm_pkg::scm_raw_t    rawIn;
	scm_pkg::scm_result_t result;
	int                   failCount = 0;
	int                   nChecks = 0;

	scm_core dut (.clk(clk), .rst_n(rst_n), .start(start), .rawIn(rawIn),
		.result(result), .done(done), .busy(busy), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .irq(irq));
	scm_conv_model conv (.clk(clk), .rawIn(rawIn), .start(start),
		.done(done));

	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] w);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= w;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] r);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		r = regRdata;
	endtask

	task automatic wcheck(input logic [7:0] a, input logic [31:0] w,
		input logic [31:0] e);
		reg_write(a, w);
		reg_read(a, rdVal);
		check(rdVal, e);
	endtask

	task automatic meas(input logic c, input logic signed [17:0] b,
		input logic signed [17:0] t, input logic [15:0] eb,
		input logic [16:0] et, input logic es);
		reg_write(`SCM_ADDR_CTRL, {31'h0, c});
		conv.measure(b, t, ok);
		check({31'h0, ok}, 32'h1);
		check({16'h0, result.bridge}, {16'h0, eb});
		check({15'h0, result.temp}, {15'h0, et});
		check({31'h0, result.sat}, {31'h0, es});
		reg_read(`SCM_ADDR_BRIDGE, rdVal);
		check(rdVal, {16'h0, eb});
		reg_read(`SCM_ADDR_MSTAT, rdVal);
		check(rdVal, {31'h0, es});
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		repeat (6000) @(posedge clk);
		failCount++;
		$display("mismatch at %0t: watchdog expired", $time);
		complete_run;
	end

	initial begin
		rst_n = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWdata = 32'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values
		wcheck(`SCM_ADDR_STAT, 32'h3, 32'h0);
		reg_read(`SCM_ADDR_CTRL, rdVal);
		check(rdVal, 32'h0);
		reg_read(`SCM_ADDR_IEN, rdVal);
		check(rdVal, 32'h0);
		reg_read(8'h1C, rdVal);
		check(rdVal, 32'h0);
		reg_read(8'h4C, rdVal);
		check(rdVal, 32'h0);
		reg_read(8'h02, rdVal);
		check(rdVal, 32'h0);
		$display("test reset finished");
		// Coefficient bounds, then working set
		wcheck(8'h00, 32'h0007FFFF, 32'h0001FFFF);
		wcheck(8'h08, 32'h00040000, 32'h0001FFFF);
		wcheck(8'h10, 32'hFFF00000, 32'hFFFF0001);
		wcheck(8'h14, 32'hFFFF0000, 32'hFFFFE001);
		wcheck(8'h1C, 32'hFFF80000, 32'hFFFE0001);
		wcheck(8'h24, 32'h00002000, 32'h00001FFF);
		wcheck(8'h00, 32'h00008000, 32'h00008000);
		wcheck(8'h08, 32'h0, 32'h0);
		wcheck(8'h10, 32'h0, 32'h0);
		wcheck(8'h14, 32'h0, 32'h0);
		wcheck(8'h1C, 32'h00001000, 32'h00001000);
		wcheck(8'h20, 32'h00008000, 32'h00008000);
		wcheck(8'h24, 32'h00000100, 32'h00000100);
		$display("test coefficients finished");
		// Both curve forms and saturation
		meas(1'b0, 18'sh01000, 18'sh00400, 16'hA440, 17'h08500, 1'b0);
		meas(1'b1, 18'sh01000, 18'sh00400, 16'h9040, 17'h08500, 1'b0);
		meas(1'b1, -18'sh01000, 18'sh00400, 16'h6FC0, 17'h08500, 1'b0);
		meas(1'b1, 18'sh1FFFF, 18'sh00400, 16'hFFFF, 17'h08500, 1'b1);
		meas(1'b1, -18'sh1FFFF, 18'sh00400, 16'h0000, 17'h08500, 1'b1);
		meas(1'b0, 18'sh10000, 18'sh00400, 16'hFFFF, 17'h08500, 1'b1);
		meas(1'b0, -18'sh09000, 18'sh00400, 16'h0000, 17'h08500, 1'b1);
		meas(1'b0, 18'sh01000, 18'sh1FFFF, 16'hA440, 17'h1FFFF, 1'b1);
		$display("test math finished");
		// Interrupt raised, cleared and masked
		wcheck(`SCM_ADDR_IEN, 32'h3, 32'h3);
		check({31'h0, irq}, 32'h1);
		reg_read(`SCM_ADDR_STAT, rdVal);
		check(rdVal, 32'h3);
		wcheck(`SCM_ADDR_CLR, 32'h3, 32'h0);
		check({31'h0, irq}, 32'h0);
		reg_write(`SCM_ADDR_IEN, 32'h1);
		meas(1'b0, 18'sh01000, 18'sh00400, 16'hA440, 17'h08500, 1'b0);
		reg_read(`SCM_ADDR_STAT, rdVal);
		check(rdVal, 32'h2);
		check({31'h0, irq}, 32'h0);
		$display("test interrupt finished");
		// Temperature drift of the gain
		wcheck(8'h08, 32'h00008000, 32'h00008000);
		meas(1'b0, 18'sh01000, 18'sh08000, 16'hB900, 17'h10100, 1'b0);
		$display("test drift finished");
		complete_run;
	end
endmodule
